// ---- verilog/rx_pkg.sv ----
// Constants, register map and types shared by the receive lane design
package rx_pkg;
   // Clock and timing
   localparam int CLK_NS       = 25;                                  // mclk period in ns
   localparam int AUTO_WIN_NS  = 1000;                                // Link activity window in ns
   localparam int AUTO_WIN_CYC = (AUTO_WIN_NS + CLK_NS - 1) / CLK_NS; // Window in mclk cycles
   localparam logic [5:0] AUTO_WIN_LOAD = 6'(AUTO_WIN_CYC);           // Counter load value

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_PATTERN  = 8'h04;
   localparam logic [7:0] OFS_STATUS   = 8'h08;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
   localparam logic [7:0] OFS_DATA     = 8'h14;

   // Control field positions
   localparam int CTRL_MANUAL  = 0;  // Lock request inputs present
   localparam int CTRL_WIDTH10 = 1;  // 10-bit interface when set
   localparam int CTRL_PLEN10  = 2;  // 10-bit interface: 10-bit pattern when set, else 7-bit
   localparam int CTRL_DIGRST  = 3;  // Receive digital reset
   localparam int CTRL_W       = 4;

   // Status and interrupt field positions
   localparam int STAT_LOCKED = 0;
   localparam int STAT_ARMED  = 1;
   localparam int STAT_ALIGN  = 2;
   localparam int IRQ_SYNC    = 0;
   localparam int IRQ_PAT     = 1;
   localparam int IRQ_LOCK    = 2;
   localparam int IRQ_W       = 3;

   // Reset values
   localparam logic [3:0]  CTRL_RST    = 4'h0;
   localparam logic [15:0] PATTERN_RST = 16'h0000;
   localparam logic [2:0]  MASK_RST    = 3'h0;

   // Data path sizes and word ends
   localparam int WIN_W = 20;             // Received bit history
   localparam int PAT_W = 16;             // Pattern register width
   localparam logic [3:0] LAST8  = 4'h7;  // Last bit index, 8-bit word
   localparam logic [3:0] LAST10 = 4'h9;  // Last bit index, 10-bit word

   // Recovery unit states
   typedef enum logic [1:0]
   {
      reference_tracking_state = 2'b01,
      data_tracking_state      = 2'b10
   } cdr_state_t;
endpackage

// ---- verilog/bit_sync.sv ----
// Two flip-flop synchroniser for a group of asynchronous levels
`timescale 1ns/100ps
`default_nettype none
module bit_sync
#(
   parameter int W = 1
)
(
   input  wire logic         mclk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_reg;  // First stage, read only by the second

   // Two stages, cleared by reset
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_reg <= '0;
         q        <= '0;
      end
      else
      begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule
`default_nettype wire

// ---- verilog/pattern_match.sv ----
// Compares the newest received bits with the alignment pattern
`timescale 1ns/100ps
`default_nettype none
module pattern_match
(
   input  wire logic [rx_pkg::WIN_W-1:0] win,
   input  wire logic [rx_pkg::PAT_W-1:0] pattern,
   input  wire logic                     width10,
   input  wire logic                     plen10,
   output logic                          match
);
   // Newest bit sits at the top; first pattern bit is its LSB
   always_comb
   begin
      if (!width10)
      begin
         // 16-bit pattern, true form only
         match = (win[19:4] == pattern);
      end
      else if (plen10)
      begin
         // 10-bit pattern or its complement
         match = (win[19:10] == pattern[9:0]) || (win[19:10] == ~pattern[9:0]);
      end
      else
      begin
         // 7-bit pattern or its complement
         match = (win[19:13] == pattern[6:0]) || (win[19:13] == ~pattern[6:0]);
      end
   end
endmodule
`default_nettype wire

// ---- verilog/rx_lane.sv ----
// Receive lane: lock control, deserializer, manual word aligner and APB registers
//
// Contract
// [RULE1] Reference state ignores data; data state tracks
// [RULE2] Manual mode: lock request levels pick state
// [RULE3] Manual mode: lock flag equals data state
// [RULE4] No lock inputs configured: automatic lock mode
// [RULE5] Serial stream becomes 8- or 10-bit words
// [RULE6] First received bit is word LSB
// [RULE7] Bits captured on both recovered clock edges
// [RULE8] Aligner restores boundary from alignment pattern
// [RULE9] Pattern 16 bits, or 7/10 bits
// [RULE10] 8-bit: align enable rise starts search
// [RULE11] 8-bit: new boundary needs another rise
// [RULE12] 10-bit: high enable searches pattern or complement
// [RULE13] 10-bit: low enable holds boundary
// [RULE14] Realign pulses sync and pattern flags
// [RULE15] Flags share data path latency
// [RULE16] Pattern on current boundary: pattern flag only
// [RULE17] User drops enable unless pattern unique
// [RULE18] Align enable synchronised before use
//
// The APB register port and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none
module rx_lane
(
   input  wire logic        mclk,           // 40 MHz system clock
   input  wire logic        nrst,           // Asynchronous reset, active low
   input  wire logic        psel,           // APB select
   input  wire logic        penable,        // APB access phase
   input  wire logic        pwrite,         // APB direction
   input  wire logic [7:0]  paddr,          // APB byte address
   input  wire logic [31:0] pwdata,         // APB write data
   output logic      [31:0] prdata,         // APB read data
   output logic             pready,         // APB ready
   output logic             pslverr,        // APB error on unmapped address
   output logic             irq,            // Level interrupt
   input  wire logic        ser_clk,        // High-speed recovered clock
   input  wire logic        ser_data,       // Serial data from input buffer
   input  wire logic        lock_ref_req,   // Lock-to-reference request
   input  wire logic        lock_data_req,  // Lock-to-data request
   input  wire logic        align_en,       // Pattern align enable
   output logic             pd_en,          // Phase detector enable
   output logic             freq_locked,    // Frequency lock indication
   output logic      [9:0]  rx_word,        // Parallel word, LSB first received
   output logic             rx_word_valid,  // One-cycle word strobe
   output logic             rx_sync,        // Boundary moved with this word
   output logic             rx_pattern      // Pattern ends on this word's last bit
);
   logic [1:0] rst_sync_reg;                  // Reset release stages
   logic       rst_n;                         // Synchronised reset
   logic [4:0] pins_s;                        // Synchronised pin levels
   logic       clk_s, data_s, ref_s, dat_s, align_s;
   logic       clk_d_reg;                     // Previous sampled link clock
   logic       link_edge;                     // Either link clock edge
   logic       bit_take;                      // Bit captured this cycle
   rx_pkg::cdr_state_t state_reg, state_next; // Recovery unit state
   logic [5:0] idle_reg;                      // Link activity timer
   logic [rx_pkg::CTRL_W-1:0] ctrl_reg;       // Control register
   logic [rx_pkg::PAT_W-1:0]  pattern_reg;    // Alignment pattern
   logic [rx_pkg::IRQ_W-1:0]  irq_stat_reg;   // Sticky events
   logic [rx_pkg::IRQ_W-1:0]  irq_mask_reg;   // Event enables
   logic [rx_pkg::IRQ_W-1:0]  irq_set;        // Events this cycle
   logic       manual, width10, plen10, dig_rst;
   logic [rx_pkg::WIN_W-1:0]  win_reg;        // Received bit history
   logic [rx_pkg::WIN_W-1:0]  win_next;       // History including new bit
   logic [3:0] bit_cnt_reg;                   // Bits in current word
   logic [3:0] last_idx;                      // Index of a word's last bit
   logic       match;                         // Pattern seen at window top
   logic       word_end;                      // New bit closes a word
   logic       realign;                       // Boundary moves here
   logic       align_d_reg;                   // Previous align enable
   logic       armed8_reg;                    // 8-bit search pending
   logic       armed;                         // Search permitted now
   logic       aligned_reg;                   // Boundary set at least once
   logic       wr_acc, rd_setup, hit;

   // Reset release through two flip-flops
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         rst_sync_reg <= 2'b00;
      else
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
   end
   assign rst_n = rst_sync_reg[1];

   // All pin levels cross into mclk here
   bit_sync #(.W(5)) u_pins
   (
      .mclk  (mclk),
      .rst_n (rst_n),
      .d     ({align_en, lock_data_req, lock_ref_req, ser_data, ser_clk}),
      .q     (pins_s)
   );
   assign clk_s   = pins_s[0];
   assign data_s  = pins_s[1];
   assign ref_s   = pins_s[2];
   assign dat_s   = pins_s[3];
   assign align_s = pins_s[4];  // see [RULE18]

   // Control fields
   assign manual  = ctrl_reg[rx_pkg::CTRL_MANUAL];
   assign width10 = ctrl_reg[rx_pkg::CTRL_WIDTH10];
   assign plen10  = ctrl_reg[rx_pkg::CTRL_PLEN10];
   assign dig_rst = ctrl_reg[rx_pkg::CTRL_DIGRST];

   // Link clock edge detect on the synchronised copy
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         clk_d_reg <= 1'b0;
      else
         clk_d_reg <= clk_s;
   end
   assign link_edge = clk_s ^ clk_d_reg;  // see [RULE7]

   // Activity timer used by automatic lock mode
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         idle_reg <= 6'h00;
      else if (link_edge)
         idle_reg <= rx_pkg::AUTO_WIN_LOAD;
      else if (idle_reg != 6'h00)
         idle_reg <= idle_reg - 6'h01;
   end

   // Next recovery state
   always_comb
   begin
      if (manual)
      begin
         // Reference request wins; both low parks on reference
         if (ref_s)
            state_next = rx_pkg::reference_tracking_state;  // see [RULE2]
         else if (dat_s)
            state_next = rx_pkg::data_tracking_state;       // see [RULE2]
         else
            state_next = rx_pkg::reference_tracking_state;
      end
      else if (idle_reg != 6'h00)
         state_next = rx_pkg::data_tracking_state;          // see [RULE4]
      else
         state_next = rx_pkg::reference_tracking_state;     // see [RULE4]
   end

   // Recovery state register
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         state_reg <= rx_pkg::reference_tracking_state;
      else if (dig_rst)
         state_reg <= rx_pkg::reference_tracking_state;
      else
      begin
         case (state_reg)
            rx_pkg::reference_tracking_state: state_reg <= state_next;
            rx_pkg::data_tracking_state:      state_reg <= state_next;
            default:                          state_reg <= rx_pkg::reference_tracking_state;
         endcase
      end
   end

   // Lock flag and phase detector follow the state
   assign freq_locked = (state_reg == rx_pkg::data_tracking_state);  // see [RULE3]
   assign pd_en       = freq_locked;                                 // see [RULE1]

   // Only data tracking takes bits from the line
   assign bit_take = link_edge && freq_locked && !dig_rst;  // see [RULE1] [RULE7]
   assign win_next = {data_s, win_reg[rx_pkg::WIN_W-1:1]};  // see [RULE6]
   assign last_idx = width10 ? rx_pkg::LAST10 : rx_pkg::LAST8;  // see [RULE5]

   // Pattern compare on history including the new bit
   pattern_match u_match
   (
      .win     (win_next),
      .pattern (pattern_reg),
      .width10 (width10),
      .plen10  (plen10),
      .match   (match)
   );  // see [RULE9]

   // Search permission: level in 10-bit mode, edge-armed in 8-bit mode
   assign armed    = width10 ? align_s : armed8_reg;  // see [RULE12] [RULE13]
   assign word_end = bit_take && (bit_cnt_reg == last_idx);
   assign realign  = bit_take && match && armed && !word_end;  // see [RULE8]

   // Bit history and word position
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         win_reg     <= '0;
         bit_cnt_reg <= 4'h0;
      end
      else if (dig_rst)
      begin
         win_reg     <= '0;
         bit_cnt_reg <= 4'h0;
      end
      else if (bit_take)
      begin
         win_reg <= win_next;
         // A move closes a word here, as a normal word end does
         if (word_end || realign)
            bit_cnt_reg <= 4'h0;  // see [RULE8]
         else
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
   end

   // 8-bit search arming from rising edges of align enable
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         align_d_reg <= 1'b1;
         armed8_reg  <= 1'b0;
      end
      else if (dig_rst)
      begin
         // A level already high at release is not an edge
         align_d_reg <= 1'b1;
         armed8_reg  <= 1'b0;
      end
      else
      begin
         align_d_reg <= align_s;
         if (align_s && !align_d_reg)
            armed8_reg <= 1'b1;  // see [RULE10]
         else if (bit_take && match)
            armed8_reg <= 1'b0;  // see [RULE11]
      end
   end

   // Word output with flags in the same stage
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_word       <= 10'h000;
         rx_word_valid <= 1'b0;
         rx_sync       <= 1'b0;
         rx_pattern    <= 1'b0;
         aligned_reg   <= 1'b0;
      end
      else
      begin
         rx_word_valid <= word_end || realign;
         rx_sync       <= realign;                                // see [RULE14] [RULE15]
         rx_pattern    <= (word_end || realign) && match;         // see [RULE14] [RULE16]
         if (word_end || realign)
            rx_word <= width10 ? win_next[19:10] : {2'b00, win_next[19:12]};  // see [RULE5] [RULE6]
         if (dig_rst)
            aligned_reg <= 1'b0;
         else if (realign)
            aligned_reg <= 1'b1;
      end
   end

   // APB decode: zero wait states, read data caught in setup
   assign wr_acc   = psel && penable && pwrite && hit;
   assign rd_setup = psel && !penable && !pwrite;
   assign pready   = 1'b1;
   assign pslverr  = psel && penable && !hit;
   always_comb
   begin
      case (paddr)
         rx_pkg::OFS_CTRL, rx_pkg::OFS_PATTERN, rx_pkg::OFS_STATUS,
         rx_pkg::OFS_IRQ_STAT, rx_pkg::OFS_IRQ_MASK, rx_pkg::OFS_DATA: hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end

   // Read data register
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         prdata <= 32'h0000_0000;
      else if (rd_setup)
      begin
         case (paddr)
            rx_pkg::OFS_CTRL:     prdata <= {28'h0, ctrl_reg};
            rx_pkg::OFS_PATTERN:  prdata <= {16'h0000, pattern_reg};
            rx_pkg::OFS_STATUS:   prdata <= {29'h0, aligned_reg, armed, freq_locked};
            rx_pkg::OFS_IRQ_STAT: prdata <= {29'h0, irq_stat_reg};
            rx_pkg::OFS_IRQ_MASK: prdata <= {29'h0, irq_mask_reg};
            rx_pkg::OFS_DATA:     prdata <= {22'h0, rx_word};
            default:              prdata <= 32'h0000_0000;
         endcase
      end
   end

   // Writable configuration
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_reg     <= rx_pkg::CTRL_RST;
         pattern_reg  <= rx_pkg::PATTERN_RST;
         irq_mask_reg <= rx_pkg::MASK_RST;
      end
      else if (wr_acc)
      begin
         if (paddr == rx_pkg::OFS_CTRL)
            ctrl_reg <= pwdata[rx_pkg::CTRL_W-1:0];
         if (paddr == rx_pkg::OFS_PATTERN)
            pattern_reg <= pwdata[rx_pkg::PAT_W-1:0];
         if (paddr == rx_pkg::OFS_IRQ_MASK)
            irq_mask_reg <= pwdata[rx_pkg::IRQ_W-1:0];
      end
   end

   // Sticky events; a new event beats a same-cycle clear
   assign irq_set = {state_next != state_reg && !dig_rst, rx_pattern && rx_word_valid, rx_sync};
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         irq_stat_reg <= '0;
      else if (wr_acc && paddr == rx_pkg::OFS_IRQ_STAT)
         irq_stat_reg <= (irq_stat_reg & ~pwdata[rx_pkg::IRQ_W-1:0]) | irq_set;
      else
         irq_stat_reg <= irq_stat_reg | irq_set;
   end
   assign irq = |(irq_stat_reg & irq_mask_reg);

   // Checks on the design's own behaviour
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   a_manual_data_lock: assert property ((manual && !dig_rst && !ref_s && dat_s) |=> freq_locked) // see [RULE2]
      else $error("data request did not lock to data");
   a_manual_ref_lock: assert property ((manual && ref_s) |=> !freq_locked) // see [RULE3]
      else $error("reference request left lock flag high");
   a_auto_idle_ref: assert property ((!manual && idle_reg == 6'h00 && !link_edge) |=> !freq_locked) // see [RULE4]
      else $error("automatic mode locked without link activity");
   a_ref_ignores_data: assert property (!freq_locked |-> !bit_take && !pd_en) // see [RULE1]
      else $error("bit taken in reference tracking");
   a_both_edges_taken: assert property ((freq_locked && !dig_rst && clk_s != $past(clk_s)) |-> bit_take) // see [RULE7]
      else $error("link clock edge missed");
   a_word_lsb_first: assert property ((word_end && !width10) |=> rx_word[0] == $past(win_reg[13])) // see [RULE6]
      else $error("first bit not in word LSB");
   a_sync_with_pattern: assert property (rx_sync |-> rx_pattern && rx_word_valid) // see [RULE14]
      else $error("sync pulse without pattern flag");
   a_sync_one_cycle: assert property (rx_sync |=> !rx_sync) // see [RULE14]
      else $error("sync pulse longer than one word");
   a_boundary_pattern: assert property ((word_end && match) |=> rx_pattern && !rx_sync) // see [RULE16]
      else $error("pattern on boundary mishandled");
   a_hold_10bit: assert property ((width10 && !align_s && bit_take) |=> !rx_sync) // see [RULE13]
      else $error("10-bit boundary moved with enable low");
   a_hold_8bit: assert property ((!width10 && !armed8_reg) |=> !rx_sync) // see [RULE11]
      else $error("8-bit boundary moved without new rise");
   a_arm_on_rise: assert property ((!width10 && !dig_rst && align_s && !align_d_reg) |=> armed8_reg) // see [RULE10]
      else $error("align rise did not arm search");

   c_realign: cover property (rx_sync ##[1:200] rx_pattern && !rx_sync);
   c_lock_data: cover property ($rose(freq_locked));
   c_ten_bit_sync: cover property (width10 && rx_sync);
endmodule
`default_nettype wire

// ---- bench/ser_tx.sv ----
// Serial transmitter model driving the recovered link clock and data
`timescale 1ns/100ps
`default_nettype none
module ser_tx
(
   output var logic ser_clk,
   output var logic ser_data
);
   // Clock stands still between frames
   initial
   begin
      ser_clk  = 1'b0;
      ser_data = 1'b0;
   end

   // Sends n bits of v, lowest bit first, one bit per link clock edge
   task automatic send(input logic [31:0] v, input int n);
      for (int i = 0; i < n; i++)
      begin
         ser_data <= v[i];
         #25;
         ser_clk <= ~ser_clk;
         #50;
         // Line shows the inverse once the bit is taken, so a late capture fails
         ser_data <= ~v[i];
         #25;
      end
   endtask
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
// Self-checking testbench for the receive lane
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic        mclk, nrst;              // Clock and reset
   logic        psel, penable, pwrite;   // APB control
   logic [7:0]  paddr;                   // APB address
   logic [31:0] pwdata, prdata;          // APB data
   logic        pready, pslverr, irq;    // APB answer and interrupt
   logic        ser_clk, ser_data;       // Link from the transmitter
   logic        lock_ref_req, lock_data_req, align_en;  // User controls
   logic        pd_en, freq_locked;      // Recovery state
   logic [9:0]  rx_word;                 // Received word
   logic        rx_word_valid, rx_sync, rx_pattern;
   logic [11:0] wq[$];                   // Flags and word of each strobe
   logic [31:0] rd;                      // Last read data
   logic        er;                      // Last error response
   int          n_fail, checks_done;

   rx_lane u_dut (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .irq(irq), .ser_clk(ser_clk), .ser_data(ser_data), .lock_ref_req(lock_ref_req),
      .lock_data_req(lock_data_req), .align_en(align_en), .pd_en(pd_en),
      .freq_locked(freq_locked), .rx_word(rx_word), .rx_word_valid(rx_word_valid),
      .rx_sync(rx_sync), .rx_pattern(rx_pattern));
   ser_tx u_tx (.ser_clk(ser_clk), .ser_data(ser_data));

   // Clock generator
   initial
   begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   // Records every word strobe
   always @(posedge mclk)
      if (rx_word_valid === 1'b1)
         wq.push_back({rx_sync, rx_pattern, rx_word});

   // Prints the counts and the verdict
   task end_sim;
      $display("checks %0d failures %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // Compares one value
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e)
      begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask

   // Compares queued word i with flags
   task getw(input int i, input logic [11:0] e);
      chk("word", {20'h0, e}, (i >= 0 && i < wq.size()) ? {20'h0, wq[i]} : 32'hx);
   endtask

   task wait_cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask

   // One APB transfer: setup, then access until pready
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do
      begin
         @(posedge mclk);
         k++;
      end
      while (pready !== 1'b1 && k < 50);
      if (k >= 50)
      begin
         n_fail++;
         end_sim;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Reset values and unmapped access
   task t_regs;
      apb(1'b0, rx_pkg::OFS_CTRL, 32'h0);
      chk("ctrl", 32'h0, rd);
      apb(1'b0, rx_pkg::OFS_IRQ_MASK, 32'h0);
      chk("mask", 32'h0, rd);
      apb(1'b0, 8'h40, 32'h0);
      chk("err", 32'h1, {31'h0, er});
   endtask

   // Manual lock by request levels, then automatic mode without activity
   task t_lock;
      apb(1'b1, rx_pkg::OFS_CTRL, 32'h1);
      lock_ref_req <= 1'b1;
      lock_data_req <= 1'b1;
      wait_cyc(8);
      chk("locked", 32'h0, {30'h0, pd_en, freq_locked});
      lock_ref_req <= 1'b0;
      wait_cyc(8);
      chk("locked", 32'h3, {30'h0, pd_en, freq_locked});
      apb(1'b0, rx_pkg::OFS_STATUS, 32'h0);
      chk("status", 32'h1, rd & 32'h1);
      apb(1'b1, rx_pkg::OFS_CTRL, 32'h0);
      wait_cyc(60);
      chk("auto", 32'h0, {31'h0, freq_locked});
      // Link activity moves automatic mode to data tracking
      u_tx.send(32'h0, 4);
      chk("auto", 32'h1, {31'h0, freq_locked});
      apb(1'b1, rx_pkg::OFS_CTRL, 32'h1);
      wait_cyc(8);
   endtask

   // Ten-bit alignment by level, hold when low, pattern and complement
   task t_align10;
      apb(1'b1, rx_pkg::OFS_CTRL, 32'hf);
      apb(1'b1, rx_pkg::OFS_CTRL, 32'h7);
      apb(1'b1, rx_pkg::OFS_PATTERN, 32'h17c);
      align_en <= 1'b1;
      wait_cyc(5);
      wq.delete();
      u_tx.send(32'h0, 3);
      u_tx.send(32'h17c, 10);
      u_tx.send(32'h2a5, 10);
      wait_cyc(12);
      getw(wq.size() - 2, {2'b11, 10'h17c});
      getw(wq.size() - 1, {2'b00, 10'h2a5});
      align_en <= 1'b0;
      wait_cyc(5);
      wq.delete();
      u_tx.send(32'h0, 4);
      u_tx.send(32'h17c, 10);
      u_tx.send(32'h0, 6);
      u_tx.send(32'h17c, 10);
      u_tx.send(32'h283, 10);
      wait_cyc(12);
      getw(0, {2'b00, 10'h3c0});
      getw(1, {2'b00, 10'h005});
      getw(2, {2'b01, 10'h17c});
      getw(3, {2'b01, 10'h283});
   endtask

   // Interrupt status, mask and clear
   task t_irq;
      apb(1'b0, rx_pkg::OFS_IRQ_STAT, 32'h0);
      chk("istat", 32'h7, rd);
      apb(1'b1, rx_pkg::OFS_IRQ_MASK, 32'h1);
      @(negedge mclk);
      chk("irq", 32'h1, {31'h0, irq});
      apb(1'b1, rx_pkg::OFS_IRQ_STAT, 32'h1);
      @(negedge mclk);
      chk("irq", 32'h0, {31'h0, irq});
      apb(1'b1, rx_pkg::OFS_IRQ_STAT, 32'h6);
      apb(1'b0, rx_pkg::OFS_IRQ_STAT, 32'h0);
      chk("istat", 32'h0, rd);
   endtask

   // Eight-bit alignment armed by a rising edge only
   task t_align8;
      apb(1'b1, rx_pkg::OFS_CTRL, 32'h9);
      apb(1'b1, rx_pkg::OFS_CTRL, 32'h1);
      apb(1'b1, rx_pkg::OFS_PATTERN, 32'h3c5a);
      align_en <= 1'b1;
      wait_cyc(5);
      wq.delete();
      u_tx.send(32'h0, 3);
      u_tx.send(32'h3c5a, 16);
      u_tx.send(32'h0, 5);
      wait_cyc(12);
      getw(wq.size() - 1, {2'b11, 10'h03c});
      wq.delete();
      u_tx.send(32'h0, 2);
      u_tx.send(32'h3c5a, 16);
      u_tx.send(32'h0, 6);
      wait_cyc(12);
      getw(0, {2'b00, 10'h000});
      getw(1, {2'b00, 10'h02d});
      getw(2, {2'b00, 10'h01e});
      align_en <= 1'b0;
      wait_cyc(5);
      align_en <= 1'b1;
      wait_cyc(5);
      wq.delete();
      u_tx.send(32'h0, 1);
      u_tx.send(32'h3c5a, 16);
      u_tx.send(32'h0, 7);
      wait_cyc(12);
      getw(wq.size() - 1, {2'b11, 10'h03c});
      apb(1'b0, rx_pkg::OFS_DATA, 32'h0);
      chk("data", 32'h3c, rd);
   endtask

   // Bounds the whole run
   initial
   begin
      #2000000;
      n_fail++;
      end_sim;
   end

   // Main sequence
   initial
   begin
      nrst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      lock_ref_req = 1'b0;
      lock_data_req = 1'b0;
      align_en = 1'b0;
      n_fail = 0;
      checks_done = 0;
      wait_cyc(16);
      nrst <= 1'b1;
      wait_cyc(4);
      t_regs;
      t_lock;
      t_align10;
      t_irq;
      t_align8;
      end_sim;
   end
endmodule
`default_nettype wire
